/* rtl/cdiir_pkg.sv */
package cdiir_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [5:0] IDX_BLK_UPPER_SET = 6'h07;
  localparam logic [5:0] IDX_BLK_UPPER_REL = 6'h08;
  localparam logic [5:0] IDX_BLK_LOWER_SET = 6'h09;
  localparam logic [5:0] IDX_BLK_LOWER_REL = 6'h0a;
  localparam logic [5:0] IDX_FILTER_INPUT_SELECT = 6'h0d;
  localparam logic [5:0] IDX_CROSSING_PERIOD_CONFIG = 6'h0e;
  localparam logic [5:0] IDX_F0_HIGH_THR_LO = 6'h0f;
  localparam logic [5:0] IDX_F0_HIGH_THR_HI = 6'h10;
  localparam logic [5:0] IDX_F0_LOW_THR_LO = 6'h11;
  localparam logic [5:0] IDX_F0_LOW_THR_HI = 6'h12;
  localparam logic [5:0] IDX_F0_OUTPUT_FORMAT = 6'h13;
  localparam logic [5:0] IDX_FILTER_OUT_LO = 6'h14;
  localparam logic [5:0] IDX_FILTER_OUT_HI = 6'h15;
  localparam logic [5:0] IDX_F1_HIGH_THR_LO = 6'h16;
  localparam logic [5:0] IDX_F1_HIGH_THR_HI = 6'h17;
  localparam logic [5:0] IDX_F1_LOW_THR_LO = 6'h18;
  localparam logic [5:0] IDX_F1_LOW_THR_HI = 6'h19;
  localparam logic [5:0] IDX_F1_OUTPUT_FORMAT = 6'h1a;
  localparam logic [5:0] IDX_DETECTOR_STATUS = 6'h1b;
  localparam logic [5:0] IDX_DWELL_LO = 6'h1d;
  localparam logic [5:0] IDX_DWELL_HI = 6'h1e;

  // field layout
  localparam int SELECT_BIT = 0;
  localparam int FORMAT_BIT = 0;
  localparam int PERIOD_MSB = 3;
  localparam int PERIOD_W = 4;
  localparam int THR_W = 16;
  localparam int FRAC_BITS = 14;
  localparam int DWELL_W = 16;
  localparam int PEAK_W = 9;
  localparam int CNT_W = 15;
  localparam int SUM_W = 17;
  localparam int IIR_SHIFT = 1;

  // reset values and the full-crossing share
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] FULL_CROSSING = 16'h4000;

  // decisions of the block peak comparator pairs
  typedef struct packed {
    logic upper;
    logic lower;
  } cdiir_blk_dec_t;

  // one channel's comparator configuration
  typedef struct packed {
    logic [15:0] high_thr;
    logic [15:0] low_thr;
    logic two_bit;
  } cdiir_chan_cfg_t;

endpackage

/* rtl/cdiir_hyst_cmp.sv */
`timescale 1ns/1ps
module cdiir_hyst_cmp (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // block peak sample
  input wire logic peak_valid,
  input wire logic [8:0] peak,
  // hysteresis pair
  input wire logic [7:0] set_thr,
  input wire logic [7:0] rel_thr,
  // decision
  output logic flag
);

  logic flag_r;

  assign flag = flag_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else if (ce && peak_valid) begin
      // set wins when both thresholds are crossed by a bad setup
      if (peak > {1'b0, set_thr}) begin
        flag_r <= 1'b1; // R11
      end else if (peak < {1'b0, rel_thr}) begin
        flag_r <= 1'b0; // R11
      end
    end
  end

endmodule

/* rtl/cdiir_chan.sv */
`timescale 1ns/1ps
module cdiir_chan (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // filter output and settings
  input wire logic signed [15:0] filt,
  input wire cdiir_pkg::cdiir_chan_cfg_t cfg,
  input wire logic [15:0] dwell,
  // comparator result
  output logic [1:0] cmp_out
);

  logic flag_r;
  logic [15:0] dwell_cnt_r;
  logic [1:0] cmp_out_r;
  logic above;
  logic below;

  assign above = filt > $signed(cfg.high_thr); // R5
  assign below = filt < $signed(cfg.low_thr); // R5
  assign cmp_out = cmp_out_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_r <= 1'b0;
      dwell_cnt_r <= cdiir_pkg::RST_WORD;
    end else if (ce) begin
      if (above) begin
        flag_r <= 1'b1; // R10
        dwell_cnt_r <= cdiir_pkg::RST_WORD;
      end else if (flag_r && below) begin
        if (dwell_cnt_r >= dwell) begin
          flag_r <= 1'b0; // R10
          dwell_cnt_r <= cdiir_pkg::RST_WORD;
        end else begin
          dwell_cnt_r <= dwell_cnt_r + 16'h0001;
        end
      end else begin
        // any cycle not below the low threshold restarts the dwell
        dwell_cnt_r <= cdiir_pkg::RST_WORD; // R10
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmp_out_r <= 2'b00;
    end else if (ce) begin
      cmp_out_r <= cfg.two_bit ? {flag_r, ~below} : {1'b0, flag_r}; // R8
    end
  end

endmodule

/* rtl/cdiir_top.sv */
`timescale 1ns/1ps
// Overview of operation
// R1: with the input select bit clear the filter sees only the upper comparator pair decision.
// R2: with the select bit set the upper and lower pair decisions form a -1, 0, +1 filter input.
// R3: a four-bit exponent N sets the crossing period to 2**N divided-clock cycles.
// R4: the longest period, at N of 15, is 32768 divided-clock cycles.
// R5: the filter output is compared with its own high and low threshold in each of two channels.
// R6: each threshold is a signed 2.14 value held in a low-byte and a high-byte register.
// R7: 4000h means crossings on every cycle and 0800h on one eighth of them, linear between.
// R8: a channel gives a one-bit result when its format bit is 0 and a two-bit result when 1.
// R9: software writes zeros to unused upper bits, and the block ignores them.
// R10: a channel flag sets above its high threshold and clears after a dwell spent below low.
// R11: two block peak comparators use set and release pairs on a 0 to 256 scale.
module cdiir_top (
  // clock, enable and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // block peak samples, one per divided clock when valid
  input wire logic block_peak_valid,
  input wire logic [8:0] block_peak,
  // channel comparator outputs
  output logic [1:0] filter0_cmp_out,
  output logic [1:0] filter1_cmp_out,
  // filter output word
  output logic [15:0] filter_out
);

  // configuration registers
  logic filter_input_select_r;
  logic [3:0] crossing_period_exponent_r;
  logic [15:0] filter0_high_threshold_r;
  logic [15:0] filter0_low_threshold_r;
  logic [15:0] filter1_high_threshold_r;
  logic [15:0] filter1_low_threshold_r;
  logic filter0_two_bit_enable_r;
  logic filter1_two_bit_enable_r;
  logic [15:0] filter_flag_dwell_count_r;
  logic [7:0] block_upper_set_threshold_r;
  logic [7:0] block_upper_release_threshold_r;
  logic [7:0] block_lower_set_threshold_r;
  logic [7:0] block_lower_release_threshold_r;

  // bus response
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] rd_nxt;
  logic hit_nxt;

  // detector datapath
  cdiir_pkg::cdiir_blk_dec_t blk_dec;
  logic signed [1:0] level;
  logic [14:0] period_cnt_r;
  logic signed [16:0] sum_r;
  logic signed [16:0] sum_nxt;
  logic signed [15:0] frac;
  logic signed [15:0] filt_r;
  logic signed [15:0] filt_nxt;
  logic period_end;
  cdiir_pkg::cdiir_chan_cfg_t cfg0;
  cdiir_pkg::cdiir_chan_cfg_t cfg1;
  logic [1:0] ch0_out;
  logic [1:0] ch1_out;

  wire logic [5:0] idx = paddr[7:2];
  wire logic aligned = (paddr[1:0] == 2'b00);
  wire logic [7:0] wbyte = pwdata[7:0];
  wire logic setup_ph = psel && !penable;
  wire logic access_ph = psel && penable;
  wire logic wr_commit = access_ph && pready_r && pwrite && !pslverr_r;

  // last count of a period of 2**n cycles
  function automatic logic [14:0] period_last(input logic [3:0] n);
    logic [15:0] span;
    span = 16'h0001 << n; // R3
    period_last = span[14:0] - 15'h0001;
  endfunction

  // share of crossing cycles as signed 2.14, full period maps to 4000h
  function automatic logic signed [15:0] to_frac(input logic signed [16:0] s,
                                                 input logic [3:0] n);
    logic signed [31:0] wide;
    wide = 32'(s) <<< cdiir_pkg::FRAC_BITS;
    wide = wide >>> n; // R7
    to_frac = wide[15:0];
  endfunction

  // zero-extend a byte field onto the read bus
  function automatic logic [31:0] rd_byte(input logic [7:0] b);
    rd_byte = {24'h00_0000, b};
  endfunction

  // block peak comparators
  cdiir_hyst_cmp u_upper_cmp (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .peak_valid(block_peak_valid),
    .peak(block_peak),
    .set_thr(block_upper_set_threshold_r),
    .rel_thr(block_upper_release_threshold_r),
    .flag(blk_dec.upper)
  );

  cdiir_hyst_cmp u_lower_cmp (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .peak_valid(block_peak_valid),
    .peak(block_peak),
    .set_thr(block_lower_set_threshold_r),
    .rel_thr(block_lower_release_threshold_r),
    .flag(blk_dec.lower)
  );

  // filter input level
  always_comb begin
    if (!filter_input_select_r) begin
      level = blk_dec.upper ? 2'sb01 : 2'sb00; // R1
    end else if (blk_dec.upper) begin
      level = 2'sb01; // R2
    end else if (blk_dec.lower) begin
      level = 2'sb00; // R2
    end else begin
      level = 2'sb11; // R2
    end
  end

  assign period_end = (period_cnt_r >= period_last(crossing_period_exponent_r)); // R4
  assign sum_nxt = sum_r + 17'(level);
  assign frac = to_frac(sum_nxt, crossing_period_exponent_r);
  // one-pole smoothing of the per-period crossing share
  assign filt_nxt = filt_r + ((frac - filt_r) >>> cdiir_pkg::IIR_SHIFT);

  // crossing period counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      period_cnt_r <= 15'h0000;
    end else if (ce) begin
      // comparing with >= keeps a shortened period from running to wrap
      period_cnt_r <= period_end ? 15'h0000 : period_cnt_r + 15'h0001; // R3
    end
  end

  // crossing accumulator
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sum_r <= 17'h0_0000;
    end else if (ce) begin
      sum_r <= period_end ? 17'h0_0000 : sum_nxt;
    end
  end

  // filter state, updated once per period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filt_r <= cdiir_pkg::RST_WORD;
    end else if (ce && period_end) begin
      filt_r <= filt_nxt;
    end
  end

  assign filter_out = filt_r;

  // channel comparators
  assign cfg0 = '{high_thr: filter0_high_threshold_r, low_thr: filter0_low_threshold_r,
                  two_bit: filter0_two_bit_enable_r};
  assign cfg1 = '{high_thr: filter1_high_threshold_r, low_thr: filter1_low_threshold_r,
                  two_bit: filter1_two_bit_enable_r};

  cdiir_chan u_chan0 (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .filt(filt_r),
    .cfg(cfg0),
    .dwell(filter_flag_dwell_count_r),
    .cmp_out(ch0_out)
  );

  cdiir_chan u_chan1 (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .filt(filt_r),
    .cfg(cfg1),
    .dwell(filter_flag_dwell_count_r),
    .cmp_out(ch1_out)
  );

  assign filter0_cmp_out = ch0_out;
  assign filter1_cmp_out = ch1_out;

  // read mux and address decode
  always_comb begin
    rd_nxt = 32'h0000_0000;
    hit_nxt = aligned;
    unique case (idx)
      cdiir_pkg::IDX_BLK_UPPER_SET: rd_nxt = rd_byte(block_upper_set_threshold_r);
      cdiir_pkg::IDX_BLK_UPPER_REL: rd_nxt = rd_byte(block_upper_release_threshold_r);
      cdiir_pkg::IDX_BLK_LOWER_SET: rd_nxt = rd_byte(block_lower_set_threshold_r);
      cdiir_pkg::IDX_BLK_LOWER_REL: rd_nxt = rd_byte(block_lower_release_threshold_r);
      cdiir_pkg::IDX_FILTER_INPUT_SELECT: rd_nxt = rd_byte({7'h00, filter_input_select_r});
      cdiir_pkg::IDX_CROSSING_PERIOD_CONFIG: begin
        rd_nxt = rd_byte({4'h0, crossing_period_exponent_r});
      end
      cdiir_pkg::IDX_F0_HIGH_THR_LO: rd_nxt = rd_byte(filter0_high_threshold_r[7:0]);
      cdiir_pkg::IDX_F0_HIGH_THR_HI: rd_nxt = rd_byte(filter0_high_threshold_r[15:8]);
      cdiir_pkg::IDX_F0_LOW_THR_LO: rd_nxt = rd_byte(filter0_low_threshold_r[7:0]);
      cdiir_pkg::IDX_F0_LOW_THR_HI: rd_nxt = rd_byte(filter0_low_threshold_r[15:8]);
      cdiir_pkg::IDX_F0_OUTPUT_FORMAT: rd_nxt = rd_byte({7'h00, filter0_two_bit_enable_r});
      cdiir_pkg::IDX_FILTER_OUT_LO: rd_nxt = rd_byte(filt_r[7:0]);
      cdiir_pkg::IDX_FILTER_OUT_HI: rd_nxt = rd_byte(filt_r[15:8]);
      cdiir_pkg::IDX_F1_HIGH_THR_LO: rd_nxt = rd_byte(filter1_high_threshold_r[7:0]);
      cdiir_pkg::IDX_F1_HIGH_THR_HI: rd_nxt = rd_byte(filter1_high_threshold_r[15:8]);
      cdiir_pkg::IDX_F1_LOW_THR_LO: rd_nxt = rd_byte(filter1_low_threshold_r[7:0]);
      cdiir_pkg::IDX_F1_LOW_THR_HI: rd_nxt = rd_byte(filter1_low_threshold_r[15:8]);
      cdiir_pkg::IDX_F1_OUTPUT_FORMAT: rd_nxt = rd_byte({7'h00, filter1_two_bit_enable_r});
      cdiir_pkg::IDX_DETECTOR_STATUS: begin
        rd_nxt = rd_byte({2'b00, ch1_out, ch0_out, blk_dec.lower, blk_dec.upper});
      end
      cdiir_pkg::IDX_DWELL_LO: rd_nxt = rd_byte(filter_flag_dwell_count_r[7:0]);
      cdiir_pkg::IDX_DWELL_HI: rd_nxt = rd_byte(filter_flag_dwell_count_r[15:8]);
      default: hit_nxt = 1'b0;
    endcase
  end

  // apb response: one wait state, write lands on the completing edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (ce) begin
      if (access_ph && !pready_r) begin
        pready_r <= 1'b1;
        prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
        pslverr_r <= !hit_nxt;
      end else begin
        pready_r <= 1'b0;
        prdata_r <= 32'h0000_0000;
        pslverr_r <= 1'b0;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // block peak threshold registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      block_upper_set_threshold_r <= cdiir_pkg::RST_BYTE;
      block_upper_release_threshold_r <= cdiir_pkg::RST_BYTE;
      block_lower_set_threshold_r <= cdiir_pkg::RST_BYTE;
      block_lower_release_threshold_r <= cdiir_pkg::RST_BYTE;
    end else if (ce && wr_commit) begin
      if (idx == cdiir_pkg::IDX_BLK_UPPER_SET) begin
        block_upper_set_threshold_r <= wbyte; // R11
      end
      if (idx == cdiir_pkg::IDX_BLK_UPPER_REL) begin
        block_upper_release_threshold_r <= wbyte; // R11
      end
      if (idx == cdiir_pkg::IDX_BLK_LOWER_SET) begin
        block_lower_set_threshold_r <= wbyte; // R11
      end
      if (idx == cdiir_pkg::IDX_BLK_LOWER_REL) begin
        block_lower_release_threshold_r <= wbyte; // R11
      end
    end
  end

  // mode registers; upper bits of the byte are dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filter_input_select_r <= 1'b0;
      crossing_period_exponent_r <= 4'h0;
      filter0_two_bit_enable_r <= 1'b0;
      filter1_two_bit_enable_r <= 1'b0;
    end else if (ce && wr_commit) begin
      if (idx == cdiir_pkg::IDX_FILTER_INPUT_SELECT) begin
        filter_input_select_r <= wbyte[cdiir_pkg::SELECT_BIT]; // R9
      end
      if (idx == cdiir_pkg::IDX_CROSSING_PERIOD_CONFIG) begin
        crossing_period_exponent_r <= wbyte[cdiir_pkg::PERIOD_MSB:0]; // R9
      end
      if (idx == cdiir_pkg::IDX_F0_OUTPUT_FORMAT) begin
        filter0_two_bit_enable_r <= wbyte[cdiir_pkg::FORMAT_BIT]; // R9
      end
      if (idx == cdiir_pkg::IDX_F1_OUTPUT_FORMAT) begin
        filter1_two_bit_enable_r <= wbyte[cdiir_pkg::FORMAT_BIT]; // R9
      end
    end
  end

  // threshold halves; bytes land independently, so a pair written in
  // two transfers is briefly mixed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filter0_high_threshold_r <= cdiir_pkg::RST_WORD;
      filter0_low_threshold_r <= cdiir_pkg::RST_WORD;
      filter1_high_threshold_r <= cdiir_pkg::RST_WORD;
      filter1_low_threshold_r <= cdiir_pkg::RST_WORD;
    end else if (ce && wr_commit) begin
      unique case (idx)
        cdiir_pkg::IDX_F0_HIGH_THR_LO: filter0_high_threshold_r[7:0] <= wbyte; // R6
        cdiir_pkg::IDX_F0_HIGH_THR_HI: filter0_high_threshold_r[15:8] <= wbyte; // R6
        cdiir_pkg::IDX_F0_LOW_THR_LO: filter0_low_threshold_r[7:0] <= wbyte; // R6
        cdiir_pkg::IDX_F0_LOW_THR_HI: filter0_low_threshold_r[15:8] <= wbyte; // R6
        cdiir_pkg::IDX_F1_HIGH_THR_LO: filter1_high_threshold_r[7:0] <= wbyte; // R6
        cdiir_pkg::IDX_F1_HIGH_THR_HI: filter1_high_threshold_r[15:8] <= wbyte; // R6
        cdiir_pkg::IDX_F1_LOW_THR_LO: filter1_low_threshold_r[7:0] <= wbyte; // R6
        cdiir_pkg::IDX_F1_LOW_THR_HI: filter1_low_threshold_r[15:8] <= wbyte; // R6
        default: begin
        end
      endcase
    end
  end

  // dwell count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filter_flag_dwell_count_r <= cdiir_pkg::RST_WORD;
    end else if (ce && wr_commit) begin
      if (idx == cdiir_pkg::IDX_DWELL_LO) begin
        filter_flag_dwell_count_r[7:0] <= wbyte; // R10
      end
      if (idx == cdiir_pkg::IDX_DWELL_HI) begin
        filter_flag_dwell_count_r[15:8] <= wbyte; // R10
      end
    end
  end

endmodule

/* verif/cdiir_top_sva.sv */
`timescale 1ns/1ps
module cdiir_top_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // detector side
  input wire logic block_peak_valid,
  input wire logic [8:0] block_peak,
  input wire logic [1:0] filter0_cmp_out,
  input wire logic [1:0] filter1_cmp_out,
  input wire logic [15:0] filter_out
);
  localparam logic [7:0] FMT0_ADDR = {cdiir_pkg::IDX_F0_OUTPUT_FORMAT, 2'b00};
  localparam logic [7:0] FMT1_ADDR = {cdiir_pkg::IDX_F1_OUTPUT_FORMAT, 2'b00};
  localparam logic [7:0] SEL_ADDR = {cdiir_pkg::IDX_FILTER_INPUT_SELECT, 2'b00};
  localparam logic [7:0] PER_ADDR = {cdiir_pkg::IDX_CROSSING_PERIOD_CONFIG, 2'b00};
  logic wr_done;
  logic fmt0_r;
  logic fmt1_r;
  // shadow of the format bits, seen only through completed bus writes
  assign wr_done = psel && penable && pready && pwrite && !pslverr;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fmt0_r <= 1'b0;
    end else if (wr_done && paddr == FMT0_ADDR) begin
      fmt0_r <= pwdata[0];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fmt1_r <= 1'b0;
    end else if (wr_done && paddr == FMT1_ADDR) begin
      fmt1_r <= pwdata[0];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_access;
    psel && penable && !pready && ce;
  endsequence
  sequence s_answer;
    ##[1:2] pready;
  endsequence
  AST_APB_ANSWER: assert property (s_access |-> s_answer)
    else $error("access phase not answered in time");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable && $past(penable))
    else $error("pready outside an access phase");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");
  AST_UNALIGNED_ERR: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("unaligned access not refused");
  AST_SEL_FMT_BITS: assert property (
    pready && !pwrite && (paddr == SEL_ADDR || paddr == FMT0_ADDR || paddr == FMT1_ADDR)
    |-> prdata[31:1] == 31'h0)
    else $error("unused select or format bits read nonzero");
  AST_PERIOD_BITS: assert property (pready && !pwrite && paddr == PER_ADDR |-> prdata[31:4] == 28'h0)
    else $error("unused period bits read nonzero");
  AST_ONE_BIT_CH0: assert property (
    !fmt0_r && !$past(fmt0_r) && !$past(fmt0_r, 2) && !$past(fmt0_r, 3)
    |-> filter0_cmp_out[1] == 1'b0)
    else $error("channel 0 upper bit set in one-bit format");
  AST_ONE_BIT_CH1: assert property (
    !fmt1_r && !$past(fmt1_r) && !$past(fmt1_r, 2) && !$past(fmt1_r, 3)
    |-> filter1_cmp_out[1] == 1'b0)
    else $error("channel 1 upper bit set in one-bit format");
  AST_RESET_CLEAN: assert property ($fell(rst) |-> filter_out == 16'h0000 && !pready
    && filter0_cmp_out == 2'b00 && filter1_cmp_out == 2'b00)
    else $error("outputs not clear after reset");
endmodule

/* verif/cdiir_top_tb.sv */
`timescale 1ns/1ps
module cdiir_top_tb;
  typedef struct packed {
    logic [5:0] idx;
    logic [7:0] wr;
    logic [7:0] rb;
  } cdiir_row_t;
  localparam cdiir_row_t ROWS [18] = '{
    '{cdiir_pkg::IDX_BLK_UPPER_SET, 8'h80, 8'h80}, '{cdiir_pkg::IDX_BLK_UPPER_REL, 8'h40, 8'h40},
    '{cdiir_pkg::IDX_BLK_LOWER_SET, 8'h20, 8'h20}, '{cdiir_pkg::IDX_BLK_LOWER_REL, 8'h10, 8'h10},
    '{cdiir_pkg::IDX_FILTER_INPUT_SELECT, 8'hfe, 8'h00},
    '{cdiir_pkg::IDX_CROSSING_PERIOD_CONFIG, 8'hf2, 8'h02},
    '{cdiir_pkg::IDX_F0_HIGH_THR_LO, 8'h11, 8'h11}, '{cdiir_pkg::IDX_F0_HIGH_THR_HI, 8'h20, 8'h20},
    '{cdiir_pkg::IDX_F0_LOW_THR_LO, 8'h22, 8'h22}, '{cdiir_pkg::IDX_F0_LOW_THR_HI, 8'h10, 8'h10},
    '{cdiir_pkg::IDX_F0_OUTPUT_FORMAT, 8'hfe, 8'h00},
    '{cdiir_pkg::IDX_F1_HIGH_THR_LO, 8'h33, 8'h33}, '{cdiir_pkg::IDX_F1_HIGH_THR_HI, 8'h20, 8'h20},
    '{cdiir_pkg::IDX_F1_LOW_THR_LO, 8'h44, 8'h44}, '{cdiir_pkg::IDX_F1_LOW_THR_HI, 8'h10, 8'h10},
    '{cdiir_pkg::IDX_F1_OUTPUT_FORMAT, 8'h03, 8'h01},
    '{cdiir_pkg::IDX_DWELL_LO, 8'h40, 8'h40}, '{cdiir_pkg::IDX_DWELL_HI, 8'h00, 8'h00}};
  localparam int DWELL = 64;
  logic clk;
  logic rst;
  logic ce;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic block_peak_valid;
  logic [8:0] block_peak;
  logic [1:0] filter0_cmp_out;
  logic [1:0] filter1_cmp_out;
  logic [15:0] filter_out;
  logic [31:0] rd;
  logic err;
  logic flag_prev = 1'b0;
  int mismatches;
  int samples_checked;
  int below_cnt = 0;
  int clear_cnt = 0;
  int gap;

  cdiir_top cdiir_top_inst (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .block_peak_valid(block_peak_valid), .block_peak(block_peak),
    .filter0_cmp_out(filter0_cmp_out), .filter1_cmp_out(filter1_cmp_out),
    .filter_out(filter_out));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // holds the request until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= {24'h00_0000, data};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      check("pready", 32'h0000_0001, 32'h0000_0000);
    end
  endtask

  // cycles between two successive filter output updates
  task automatic measure_gap(output int g);
    logic [15:0] last;
    int n;
    n = 0;
    @(posedge clk);
    last = filter_out;
    while (filter_out === last && n < 70000) begin
      @(posedge clk);
      n++;
    end
    last = filter_out;
    g = 0;
    while (filter_out === last && g < 70000) begin
      @(posedge clk);
      g++;
    end
  endtask

  function automatic logic [15:0] settle(input int share);
    int y = 0;
    repeat (40) y = y + ((share - y) >>> 1);
    return y[15:0];
  endfunction

  // how long the output stayed below the low threshold before the flag fell
  always @(posedge clk) begin
    below_cnt <= ($signed(filter_out) < $signed(16'h1022)) ? below_cnt + 1 : 0;
    if (filter0_cmp_out[0] === 1'b0 && flag_prev === 1'b1) begin
      clear_cnt <= below_cnt;
    end
    flag_prev <= filter0_cmp_out[0];
  end

  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    $display("watchdog expired");
    conclude();
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    block_peak_valid = 1'b1;
    block_peak = 9'h000;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    foreach (ROWS[i]) begin
      apb(1'b0, {ROWS[i].idx, 2'b00}, 8'h00);
      check("reset value", 32'h0000_0000, rd);
      apb(1'b1, {ROWS[i].idx, 2'b00}, ROWS[i].wr);
      apb(1'b0, {ROWS[i].idx, 2'b00}, 8'h00);
      check("readback", {24'h00_0000, ROWS[i].rb}, rd);
      check("no error", 32'h0000_0000, {31'h0, err});
    end
    $display("test registers done");
    apb(1'b0, 8'hfc, 8'h00);
    check("unmapped err", 32'h0000_0001, {31'h0, err});
    check("unmapped data", 32'h0000_0000, rd);
    apb(1'b1, {cdiir_pkg::IDX_FILTER_INPUT_SELECT, 2'b01}, 8'h01);
    check("unaligned err", 32'h0000_0001, {31'h0, err});
    apb(1'b1, {cdiir_pkg::IDX_DETECTOR_STATUS, 2'b00}, 8'hff);
    check("read-only write err", 32'h0000_0000, {31'h0, err});
    $display("test refusals done");
    block_peak <= 9'h100;
    measure_gap(gap);
    check("period n2", 32'd4, gap);
    repeat (200) @(posedge clk);
    check("upper-only filter", {16'h0, settle(32'h0000_4000)}, {16'h0, filter_out});
    check("ch0 one-bit", 32'h0000_0001, {30'h0, filter0_cmp_out});
    check("ch1 two-bit", 32'h0000_0003, {30'h0, filter1_cmp_out});
    apb(1'b0, {cdiir_pkg::IDX_FILTER_OUT_HI, 2'b00}, 8'h00);
    check("filter out high byte", 32'h0000_003f, rd);
    apb(1'b0, {cdiir_pkg::IDX_DETECTOR_STATUS, 2'b00}, 8'h00);
    check("status", 32'h0000_0037, rd);
    $display("test upper input done");
    apb(1'b1, {cdiir_pkg::IDX_FILTER_INPUT_SELECT, 2'b00}, 8'h01);
    apb(1'b1, {cdiir_pkg::IDX_CROSSING_PERIOD_CONFIG, 2'b00}, 8'h03);
    block_peak <= 9'h000;
    // enable low must hold the filter and channels where they stand
    ce <= 1'b0;
    repeat (40) @(posedge clk);
    check("frozen filter", 32'h0000_3fff, {16'h0, filter_out});
    check("frozen ch1", 32'h0000_0003, {30'h0, filter1_cmp_out});
    ce <= 1'b1;
    measure_gap(gap);
    check("period n3", 32'd8, gap);
    repeat (400) @(posedge clk);
    check("three-level filter", {16'h0, settle(-32'sd16384)}, {16'h0, filter_out});
    check("ch0 cleared", 32'h0000_0000, {30'h0, filter0_cmp_out});
    check("ch1 below low", 32'h0000_0000, {30'h0, filter1_cmp_out});
    check("dwell span", 32'h0000_0001, {31'h0, clear_cnt >= DWELL && clear_cnt <= DWELL + 4});
    $display("test three-level input done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    check("reset filter", 32'h0000_0000, {16'h0, filter_out});
    rst <= 1'b0;
    apb(1'b0, {cdiir_pkg::IDX_FILTER_INPUT_SELECT, 2'b00}, 8'h00);
    check("select after reset", 32'h0000_0000, rd);
    $display("test mid-run reset done");
    apb(1'b1, {cdiir_pkg::IDX_BLK_UPPER_SET, 2'b00}, 8'h80);
    apb(1'b1, {cdiir_pkg::IDX_CROSSING_PERIOD_CONFIG, 2'b00}, 8'h0f);
    block_peak <= 9'h100;
    measure_gap(gap);
    check("period n15", 32'd32768, gap);
    $display("test longest period done");
    conclude();
  end
endmodule

bind cdiir_top cdiir_top_sva cdiir_top_sva_inst (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .block_peak_valid(block_peak_valid),
  .block_peak(block_peak), .filter0_cmp_out(filter0_cmp_out),
  .filter1_cmp_out(filter1_cmp_out), .filter_out(filter_out));
